// [rtl/atc_store.sv]
// Address translation cache with masked invalidation
`timescale 1ns/10ps
module atc_store
   import pf_tph_ats_pkg::*;
#(
   parameter int ENTRIES = 8,
   parameter int AW = 32
)
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic fill_i,
   input wire logic [AW-1:0] fill_addr_i,
   input wire logic inv_i,
   input wire logic [AW-1:0] inv_addr_i,
   input wire logic [AW-1:0] inv_mask_i,
   input wire logic [AW-1:0] lookup_addr_i,
   output logic hit_o
);

   localparam int PW = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;

   typedef struct packed
   {
      logic [ENTRIES-1:0] valid;
      logic [ENTRIES-1:0][AW-1:0] tag;
      logic [PW-1:0] ptr;
   } atc_state_t;

   atc_state_t state_reg;
   atc_state_t state_next;
   logic [ENTRIES-1:0] inv_match;
   logic [ENTRIES-1:0] look_match;
   logic [ENTRIES-1:0] stale;
   logic [AW-1:0] chk_addr_reg;
   logic [AW-1:0] chk_mask_reg;

   genvar g;
   generate
      for (g = 0; g < ENTRIES; g++)
      begin : entry
         assign inv_match[g] = ((state_reg.tag[g] ^ inv_addr_i) & inv_mask_i) == '0;
         assign look_match[g] = state_reg.valid[g] && (state_reg.tag[g] == lookup_addr_i);
         assign stale[g] = state_reg.valid[g] &&
                           (((state_reg.tag[g] ^ chk_addr_reg) & chk_mask_reg) == '0);
      end
   endgenerate

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb
   begin
      state_next = state_reg;
      // Invalidate first so a fill in the same cycle is a fresh translation
      if (inv_i)
      begin
         state_next.valid = state_reg.valid & ~inv_match;
      end
      if (fill_i)
      begin
         state_next.valid[state_reg.ptr] = 1'b1;
         state_next.tag[state_reg.ptr] = fill_addr_i;
         if (state_reg.ptr == PW'(ENTRIES - 1))
         begin
            state_next.ptr = '0;
         end
         else
         begin
            state_next.ptr = state_reg.ptr + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // Assertion helper only
   always_ff @(posedge clk_i)
   begin
      chk_addr_reg <= inv_addr_i;
      chk_mask_reg <= inv_mask_i;
   end

   assign hit_o = |look_match;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   inv_no_stale_a: assert property ($past(inv_i) && !$past(fill_i) |-> stale == '0)
      else $error("Stale translation left after invalidate");

endmodule

// [rtl/pf_tph_ats_capability_config.sv]
// Shared PF steering tag, ATS invalidate and payload capability logic
//
// Overview of operation
// - Interrupt mode picks tag by vector number.
// - Device mode picks tag from table entry.
// - Table location codes none, capability, MSI-X.
// - Table size 0 to 2047 two-byte entries.
// - One setting set shared by all functions.
// - Cap outstanding invalidates per PF, then backpressure.
// - Invalidate removes matching translations from cache.
// - Max payload read-only at capability bits 2:0.
// - Single max payload value for every function.
`timescale 1ns/10ps
`include "pf_tph_ats_defs.svh"
module pf_tph_ats_capability_config
   import pf_tph_ats_pkg::*;
#(
   parameter int NUM_PF = 4,
   parameter int AW = 32,
   parameter int ATC_ENTRIES = 8,
   parameter bit INT_MODE_EN = 1'b1,
   parameter bit DEV_MODE_EN = 1'b1,
   parameter st_loc_t ST_TABLE_LOC = ST_LOC_CAP,
   parameter logic [10:0] ST_TABLE_SIZE = `DEF_ST_TABLE_SIZE,
   parameter int MAX_INV_OUT = `DEF_MAX_INV_OUT,
   parameter mps_t MAX_PAYLOAD = MPS_128
)
(
   input wire logic CLOCK_I,
   input wire logic RST_N_I,
   input wire logic CFG_RD_I,
   input wire logic [11:0] CFG_ADDR_I,
   input wire logic [$clog2(NUM_PF)-1:0] CFG_FUNC_I,
   output logic CFG_RVALID_O,
   output logic [31:0] CFG_RDATA_O,
   input wire logic TPH_REQ_I,
   input wire logic TPH_VEC_VALID_I,
   input wire logic [10:0] TPH_VECTOR_I,
   input wire logic [10:0] TPH_ENTRY_I,
   output logic ST_VALID_O,
   output logic [10:0] ST_INDEX_O,
   output logic ST_IN_MSIX_O,
   output logic [1:0] ST_TABLE_LOC_O,
   output logic [10:0] ST_TABLE_SIZE_O,
   input wire logic INV_REQ_I,
   input wire logic [$clog2(NUM_PF)-1:0] INV_PF_I,
   input wire logic [AW-1:0] INV_ADDR_I,
   input wire logic [AW-1:0] INV_MASK_I,
   output logic [NUM_PF-1:0] INV_READY_O,
   output logic INV_DONE_O,
   output logic [$clog2(NUM_PF)-1:0] INV_DONE_PF_O,
   input wire logic INV_CPL_SENT_I,
   input wire logic [$clog2(NUM_PF)-1:0] INV_CPL_PF_I,
   input wire logic ATC_FILL_I,
   input wire logic [AW-1:0] ATC_FILL_ADDR_I,
   input wire logic [AW-1:0] ATC_LOOKUP_ADDR_I,
   output logic ATC_HIT_O
);

   localparam int PFW = $clog2(NUM_PF);
   localparam int CW = 6;
   localparam logic [CW-1:0] INV_CAP = (MAX_INV_OUT > `MAX_INV_OUT_LIMIT) ?
                                       CW'(`MAX_INV_OUT_LIMIT) : CW'(MAX_INV_OUT);
   // Out-of-range payload settings saturate rather than advertise a reserved code
   localparam logic [2:0] MPS_CODE = (MAX_PAYLOAD > MPS_2048) ? MPS_2048 : MAX_PAYLOAD;
   localparam logic [1:0] LOC_CODE = (ST_TABLE_LOC > ST_LOC_MSIX) ? ST_LOC_NONE : ST_TABLE_LOC;

   typedef struct packed
   {
      logic rvalid;
      logic [31:0] rdata;
      logic st_valid;
      logic [10:0] st_index;
      logic st_in_msix;
      logic [1:0] st_loc;
      logic [10:0] st_size;
      logic [NUM_PF-1:0][CW-1:0] inv_cnt;
      logic [NUM_PF-1:0] inv_ready;
      logic inv_done;
      logic [PFW-1:0] inv_done_pf;
      logic atc_hit;
   } cfg_state_t;

   cfg_state_t state_reg;
   cfg_state_t state_next;
   logic [NUM_PF-1:0][CW-1:0] cnt_next;
   logic [NUM_PF-1:0] ready_next;
   logic inv_accept;
   logic atc_hit;

   // ---------------------------------------------------------------
   // Per-function invalidate credit
   // ---------------------------------------------------------------
   assign inv_accept = INV_REQ_I && state_reg.inv_ready[INV_PF_I];

   genvar g;
   generate
      for (g = 0; g < NUM_PF; g++)
      begin : pf
         logic inc;
         logic dec;
         assign inc = inv_accept && (INV_PF_I == PFW'(g));
         // Completion for a function with nothing outstanding is ignored
         assign dec = INV_CPL_SENT_I && (INV_CPL_PF_I == PFW'(g)) &&
                      (state_reg.inv_cnt[g] != '0);
         assign cnt_next[g] = state_reg.inv_cnt[g] + CW'(inc) - CW'(dec);
         assign ready_next[g] = cnt_next[g] < INV_CAP;
      end
   endgenerate

   atc_store #(
      .ENTRIES(ATC_ENTRIES),
      .AW(AW)
   ) u_atc (
      .clk_i(CLOCK_I),
      .rst_n_i(RST_N_I),
      .fill_i(ATC_FILL_I),
      .fill_addr_i(ATC_FILL_ADDR_I),
      .inv_i(inv_accept),
      .inv_addr_i(INV_ADDR_I),
      .inv_mask_i(INV_MASK_I),
      .lookup_addr_i(ATC_LOOKUP_ADDR_I),
      .hit_o(atc_hit)
   );

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb
   begin
      state_next = state_reg;
      state_next.st_loc = LOC_CODE;
      state_next.st_size = ST_TABLE_SIZE;
      state_next.inv_cnt = cnt_next;
      state_next.inv_ready = ready_next;
      state_next.inv_done = inv_accept;
      state_next.inv_done_pf = INV_PF_I;
      state_next.atc_hit = atc_hit;

      // Config read; function number is ignored as all PFs share one value
      state_next.rvalid = CFG_RD_I;
      state_next.rdata = '0;
      if (CFG_RD_I && (CFG_ADDR_I == `DEVCAP_OFFSET))
      begin
         state_next.rdata[`DEVCAP_MPS_MSB:`DEVCAP_MPS_LSB] = MPS_CODE;
      end

      // No per-PF input: tag choice is common to every function
      state_next.st_valid = 1'b0;
      state_next.st_index = state_reg.st_index;
      state_next.st_in_msix = (LOC_CODE == ST_LOC_MSIX);
      if (TPH_REQ_I && (LOC_CODE != ST_LOC_NONE))
      begin
         if (INT_MODE_EN && TPH_VEC_VALID_I)
         begin
            state_next.st_index = TPH_VECTOR_I;
            state_next.st_valid = TPH_VECTOR_I < ST_TABLE_SIZE;
         end
         else if (DEV_MODE_EN)
         begin
            state_next.st_index = TPH_ENTRY_I;
            state_next.st_valid = TPH_ENTRY_I < ST_TABLE_SIZE;
         end
      end
   end

   always_ff @(posedge CLOCK_I)
   begin
      if (!RST_N_I)
      begin
         state_reg <= '0;
         state_reg.st_loc <= LOC_CODE;
         state_reg.st_size <= ST_TABLE_SIZE;
         state_reg.st_in_msix <= (LOC_CODE == ST_LOC_MSIX);
         state_reg.inv_ready <= (INV_CAP != '0) ? '1 : '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign CFG_RVALID_O = state_reg.rvalid;
   assign CFG_RDATA_O = state_reg.rdata;
   assign ST_VALID_O = state_reg.st_valid;
   assign ST_INDEX_O = state_reg.st_index;
   assign ST_IN_MSIX_O = state_reg.st_in_msix;
   assign ST_TABLE_LOC_O = state_reg.st_loc;
   assign ST_TABLE_SIZE_O = state_reg.st_size;
   assign INV_READY_O = state_reg.inv_ready;
   assign INV_DONE_O = state_reg.inv_done;
   assign INV_DONE_PF_O = state_reg.inv_done_pf;
   assign ATC_HIT_O = state_reg.atc_hit;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!RST_N_I);

   st_intr_sel_a: assert property (TPH_REQ_I && TPH_VEC_VALID_I && INT_MODE_EN &&
      (LOC_CODE != ST_LOC_NONE) |=> ST_INDEX_O == $past(TPH_VECTOR_I))
      else $error("Tag index not taken from vector");
   st_dev_sel_a: assert property (TPH_REQ_I && !(TPH_VEC_VALID_I && INT_MODE_EN) &&
      DEV_MODE_EN && (LOC_CODE != ST_LOC_NONE) |=> ST_INDEX_O == $past(TPH_ENTRY_I))
      else $error("Tag index not taken from table entry");
   st_loc_code_a: assert property (ST_TABLE_LOC_O == LOC_CODE && ST_TABLE_LOC_O != 2'h3 &&
      ST_IN_MSIX_O == (ST_TABLE_LOC_O == ST_LOC_MSIX))
      else $error("Table location encoding wrong");
   st_size_bound_a: assert property (ST_VALID_O |->
      ST_INDEX_O < ST_TABLE_SIZE_O && ST_TABLE_LOC_O != ST_LOC_NONE)
      else $error("Tag issued outside table");
   st_no_req_a: assert property (!TPH_REQ_I |=> !ST_VALID_O)
      else $error("Tag issued without request");
   inv_full_block_a: assert property (INV_REQ_I && !INV_READY_O[INV_PF_I]
      |=> !INV_DONE_O)
      else $error("Invalidate taken under backpressure");
   inv_cap_a: assert property (INV_DONE_O |->
      $past(INV_READY_O[INV_PF_I]) && INV_DONE_PF_O == $past(INV_PF_I))
      else $error("Invalidate accepted beyond limit");
   mps_field_a: assert property (CFG_RD_I && CFG_ADDR_I == `DEVCAP_OFFSET |=>
      CFG_RVALID_O && CFG_RDATA_O == {29'h0, MPS_CODE})
      else $error("Payload capability read wrong");
   mps_same_pf_a: assert property (CFG_RD_I && CFG_ADDR_I == `DEVCAP_OFFSET ##1
      CFG_RD_I && CFG_ADDR_I == `DEVCAP_OFFSET && CFG_FUNC_I != $past(CFG_FUNC_I)
      |=> CFG_RDATA_O == $past(CFG_RDATA_O))
      else $error("Payload differs between functions");
   mps_legal_a: assert property (CFG_RVALID_O |-> CFG_RDATA_O[2:0] <= 3'h4)
      else $error("Reserved payload code");

   intr_sel_c: cover property (TPH_REQ_I && TPH_VEC_VALID_I ##1 ST_VALID_O);
   dev_sel_c: cover property (TPH_REQ_I && !TPH_VEC_VALID_I ##1 ST_VALID_O);
   backpressure_c: cover property (INV_READY_O != '1 ##1 INV_REQ_I && !INV_READY_O[INV_PF_I]);
   devcap_rd_c: cover property (CFG_RD_I && CFG_ADDR_I == `DEVCAP_OFFSET);

endmodule

// [rtl/pf_tph_ats_defs.svh]
// Constant definitions for the TPH/ATS capability configuration block
`ifndef PF_TPH_ATS_DEFS_SVH
`define PF_TPH_ATS_DEFS_SVH

`define DEVCAP_OFFSET 12'h084
`define DEVCAP_MPS_MSB 2
`define DEVCAP_MPS_LSB 0
`define DEF_MAX_INV_OUT 32
`define MAX_INV_OUT_LIMIT 32
`define DEF_ST_TABLE_SIZE 11'h000
`define ST_TABLE_SIZE_MAX 2047
`define CFG_READ_LATENCY 1

`endif

// [rtl/pf_tph_ats_pkg.sv]
// Types shared by the TPH/ATS capability configuration block
package pf_tph_ats_pkg;

   typedef enum logic [1:0]
   {
      ST_LOC_NONE = 2'h0,
      ST_LOC_CAP = 2'h1,
      ST_LOC_MSIX = 2'h2
   } st_loc_t;

   typedef enum logic [2:0]
   {
      MPS_128 = 3'h0,
      MPS_256 = 3'h1,
      MPS_512 = 3'h2,
      MPS_1024 = 3'h3,
      MPS_2048 = 3'h4
   } mps_t;

endpackage

// [testbench/rc_agent.sv]
// Root complex translation agent model: invalidates out, completions back
`timescale 1ns/10ps
module rc_agent
(
   input wire logic clk_i,
   input wire logic go_i,
   input wire logic force_i,
   input wire logic [1:0] pf_i,
   input wire logic [31:0] addr_i,
   input wire logic [31:0] mask_i,
   input wire logic hold_i,
   input wire logic [3:0] ready_i,
   input wire logic done_i,
   input wire logic [1:0] done_pf_i,
   output logic req_o,
   output logic [1:0] pf_o,
   output logic [31:0] addr_o,
   output logic [31:0] mask_o,
   output logic cpl_o,
   output logic [1:0] cpl_pf_o
);
   logic [1:0] owed [$];
   initial
   begin
      req_o = 1'b0;
      pf_o = 2'h0;
      addr_o = 32'h0;
      mask_o = 32'h0;
      cpl_o = 1'b0;
      cpl_pf_o = 2'h0;
   end
   // Each finished invalidate owes exactly one completion
   always @(posedge clk_i)
      if (done_i === 1'b1) owed.push_back(done_pf_i);
   // Released lines toggle so stale values never look valid
   always @(negedge clk_i)
   begin
      req_o <= go_i && (force_i || ready_i[pf_i]);
      pf_o <= go_i ? pf_i : ~pf_o;
      addr_o <= go_i ? addr_i : ~addr_o;
      mask_o <= go_i ? mask_i : ~mask_o;
      cpl_o <= !hold_i && owed.size() > 0;
      cpl_pf_o <= (!hold_i && owed.size() > 0) ? owed.pop_front() : ~cpl_pf_o;
   end
endmodule

// [testbench/tb_top.sv]
// Self-checking bench for the shared PF capability configuration block
`timescale 1ns/10ps
module tb_top import pf_tph_ats_pkg::*;;
   typedef struct packed {logic k; logic [1:0] f; logic [11:0] a; logic v;
      logic [10:0] n; logic ev; logic [31:0] ed;} row_t;
   logic clk = 1'b0, rst_n = 1'b0, cfg_rd = 1'b0, tph_req = 1'b0, vec_valid = 1'b0;
   logic [11:0] cfg_addr = 12'h0;
   logic [1:0] cfg_func = 2'h0, inv_pf, done_pf, cpl_pf, a_pf = 2'h0;
   logic [10:0] vector = 11'h0, entry = 11'h0, st_index, st_size;
   logic [1:0] st_loc;
   logic [31:0] cfg_rdata, inv_addr, inv_mask, a_addr = 32'h0, a_mask = 32'h0;
   logic [31:0] fill_addr = 32'h0, look_addr = 32'h0;
   logic [3:0] inv_ready;
   logic cfg_rvalid, st_valid, st_msix, inv_req, inv_done, cpl, hit;
   logic fill = 1'b0, go = 1'b0, frc = 1'b0, hold = 1'b1;
   logic [1:0] last_pf = 2'h0;
   int n_mismatch = 0, n_tests = 0, n_done = 0;
   row_t r;
   row_t rows [7] = '{
      '{1'b0, 2'h0, 12'h084, 1'b0, 11'h0, 1'b1, 32'h2},
      '{1'b0, 2'h3, 12'h084, 1'b0, 11'h0, 1'b1, 32'h2},
      '{1'b0, 2'h1, 12'h088, 1'b0, 11'h0, 1'b1, 32'h0},
      '{1'b1, 2'h0, 12'h0, 1'b1, 11'h005, 1'b1, 32'h5},
      '{1'b1, 2'h0, 12'h0, 1'b0, 11'h00f, 1'b1, 32'hf},
      '{1'b1, 2'h0, 12'h0, 1'b0, 11'h010, 1'b0, 32'h0},
      '{1'b1, 2'h0, 12'h0, 1'b1, 11'h010, 1'b0, 32'h0}};
   always #50 clk = ~clk;
   always @(posedge clk)
      if (inv_done === 1'b1)
      begin
         n_done++;
         last_pf <= done_pf;
      end
   // One payload value serves all four functions
   pf_tph_ats_capability_config #(.NUM_PF(4), .ST_TABLE_SIZE(11'h010), .MAX_INV_OUT(2),
      .MAX_PAYLOAD(MPS_512)) DUT (
      .CLOCK_I(clk), .RST_N_I(rst_n), .CFG_RD_I(cfg_rd), .CFG_ADDR_I(cfg_addr),
      .CFG_FUNC_I(cfg_func), .CFG_RVALID_O(cfg_rvalid), .CFG_RDATA_O(cfg_rdata),
      .TPH_REQ_I(tph_req), .TPH_VEC_VALID_I(vec_valid), .TPH_VECTOR_I(vector),
      .TPH_ENTRY_I(entry), .ST_VALID_O(st_valid), .ST_INDEX_O(st_index),
      .ST_IN_MSIX_O(st_msix), .ST_TABLE_LOC_O(st_loc), .ST_TABLE_SIZE_O(st_size),
      .INV_REQ_I(inv_req), .INV_PF_I(inv_pf), .INV_ADDR_I(inv_addr), .INV_MASK_I(inv_mask),
      .INV_READY_O(inv_ready), .INV_DONE_O(inv_done), .INV_DONE_PF_O(done_pf),
      .INV_CPL_SENT_I(cpl), .INV_CPL_PF_I(cpl_pf), .ATC_FILL_I(fill),
      .ATC_FILL_ADDR_I(fill_addr), .ATC_LOOKUP_ADDR_I(look_addr), .ATC_HIT_O(hit));
   rc_agent agent (.clk_i(clk), .go_i(go), .force_i(frc), .pf_i(a_pf), .addr_i(a_addr),
      .mask_i(a_mask), .hold_i(hold), .ready_i(inv_ready), .done_i(inv_done),
      .done_pf_i(done_pf), .req_o(inv_req), .pf_o(inv_pf), .addr_o(inv_addr),
      .mask_o(inv_mask), .cpl_o(cpl), .cpl_pf_o(cpl_pf));
   task automatic stop_test;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Agent samples go one falling edge late, then needs a cycle for done
   task automatic issue(input logic [1:0] pf, input logic [31:0] ad, input logic f);
      go <= 1'b1;
      frc <= f;
      a_pf <= pf;
      a_addr <= ad;
      a_mask <= 32'hffffffff;
      @(negedge clk);
      go <= 1'b0;
      repeat (3) @(negedge clk);
   endtask
   task automatic look(input logic [31:0] ad, input logic exp);
      look_addr <= ad;
      @(negedge clk);
      @(negedge clk);
      check(hit, exp);
   endtask
   initial
   begin
      int i;
      repeat (8) @(negedge clk);
      // --------------------------------------------------------------
      // Reset values
      // --------------------------------------------------------------
      check(inv_ready, 4'hf);
      check(cfg_rvalid, 1'b0);
      check(st_loc, 2'h1);
      rst_n <= 1'b1;
      @(negedge clk);
      check({st_msix, st_loc, st_size}, {1'b0, 2'h1, 11'h010});
      // --------------------------------------------------------------
      // Table of reads and tag requests
      // --------------------------------------------------------------
      foreach (rows[j])
      begin
         r = rows[j];
         cfg_rd <= ~r.k;
         cfg_func <= r.f;
         cfg_addr <= r.a;
         tph_req <= r.k;
         vec_valid <= r.v;
         vector <= r.v ? r.n : r.n + 11'h3;
         entry <= r.v ? r.n + 11'h3 : r.n;
         @(negedge clk);
         check(r.k ? st_valid : cfg_rvalid, r.ev);
         if (r.ev) check(r.k ? {21'h0, st_index} : cfg_rdata, r.ed);
      end
      cfg_rd <= 1'b0;
      tph_req <= 1'b0;
      @(negedge clk);
      check({cfg_rvalid, st_valid}, 2'h0);
      check(cfg_rdata, 32'h0);
      // --------------------------------------------------------------
      // Outstanding invalidate limit and backpressure
      // --------------------------------------------------------------
      issue(2'h1, 32'h0, 1'b0);
      issue(2'h1, 32'h0, 1'b0);
      check(n_done, 2);
      check(last_pf, 2'h1);
      check(inv_ready, 4'hd);
      issue(2'h1, 32'h0, 1'b1);
      check(n_done, 2);
      hold <= 1'b0;
      for (i = 0; i < 20 && inv_ready !== 4'hf; i++) @(negedge clk);
      if (i == 20)
      begin
         n_mismatch++;
      end
      check(inv_ready, 4'hf);
      // --------------------------------------------------------------
      // Invalidate removes only matching translations
      // --------------------------------------------------------------
      fill <= 1'b1;
      fill_addr <= 32'h10000000;
      @(negedge clk);
      fill_addr <= 32'h20000000;
      @(negedge clk);
      fill <= 1'b0;
      look(32'h10000000, 1'b1);
      issue(2'h0, 32'h10000000, 1'b0);
      check(last_pf, 2'h0);
      look(32'h10000000, 1'b0);
      look(32'h20000000, 1'b1);
      stop_test;
   end
endmodule
